// ===== sau_regs.svh
// Offsets, field positions and reset values of the segmented address unit
`ifndef SAU_REGS_SVH
`define SAU_REGS_SVH
`define SAU_SEG_SHIFT 4
`define SAU_RELOC_OFF 8'hfe
`define SAU_RELOC_RESET 16'h20ff
`define SAU_RELOC_WMASK 16'h7fff
`define SAU_RELOC_BASE_MSB 11
`define SAU_RELOC_MEM_BIT 12
`define SAU_RELOC_TRAP_BIT 13
`define SAU_RELOC_SLAVE_BIT 14
`define SAU_INT_LO 8'h20
`define SAU_INT_HI 8'h3e
`define SAU_TMR0_LO 8'h50
`define SAU_TMR0_HI 8'h56
`define SAU_TMR1_LO 8'h58
`define SAU_TMR1_HI 8'h5e
`define SAU_TMR2_LO 8'h60
`define SAU_TMR2_HI 8'h66
`define SAU_CHIPSEL_LO 8'ha0
`define SAU_CHIPSEL_HI 8'ha8
`define SAU_DMA0_LO 8'hc0
`define SAU_DMA0_HI 8'hca
`define SAU_DMA1_LO 8'hd0
`define SAU_DMA1_HI 8'hda
`define SAU_RSVD_PORT_LO 16'h00f8
`define SAU_RSVD_PORT_HI 16'h00ff
`endif

// ===== sau_pkg.sv
// Types shared by the segmented address unit
package sau_pkg;
   typedef enum logic [1:0] {
      SEG_EXTRA = 2'h0, SEG_CODE = 2'h1, SEG_STACK = 2'h2, SEG_DATA = 2'h3
   } sau_seg_t;
   typedef enum logic [1:0] {
      REF_CODE = 2'h0, REF_STACK = 2'h1, REF_DATA = 2'h2,
      REF_STRING_DST = 2'h3
   } sau_ref_t;
   typedef enum logic [2:0] {
      MODE_DIRECT = 3'h0, MODE_REG_IND = 3'h1, MODE_BASED = 3'h2,
      MODE_INDEXED = 3'h3, MODE_BASED_IDX = 3'h4, MODE_BASED_IDX_DISP = 3'h5
   } sau_mode_t;
   typedef enum logic {BASE_GENERAL = 1'h0, BASE_FRAME = 1'h1} sau_base_t;
   typedef enum logic {IDX_SOURCE = 1'h0, IDX_DEST = 1'h1} sau_idx_t;
   typedef enum logic [3:0] {
      RGN_NONE = 4'h0, RGN_INT = 4'h1, RGN_TMR0 = 4'h2, RGN_TMR1 = 4'h3,
      RGN_TMR2 = 4'h4, RGN_CHIPSEL = 4'h5, RGN_DMA0 = 4'h6, RGN_DMA1 = 4'h7,
      RGN_RELOC = 4'h8
   } sau_region_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic is_io;
      logic io_from_reg;
      logic [7:0] io_port8;
      sau_ref_t kind;
      sau_mode_t mode;
      sau_base_t base_sel;
      sau_idx_t index_sel;
      logic ind_use_base;
      logic [15:0] disp;
      logic disp8;
      logic ovr_valid;
      sau_seg_t ovr_seg;
      logic [15:0] wdata;
   } sau_req_t;
   typedef struct packed {
      logic [15:0] code_segment_reg;
      logic [15:0] stack_segment_reg;
      logic [15:0] data_segment_reg;
      logic [15:0] extra_segment_reg;
      logic [15:0] instr_ptr_reg;
      logic [15:0] stack_ptr_reg;
      logic [15:0] general_base_reg;
      logic [15:0] frame_base_reg;
      logic [15:0] src_index_reg;
      logic [15:0] dest_index_reg;
      logic [15:0] port_pointer_reg;
   } sau_cpu_regs_t;
   typedef struct packed {
      logic [15:0] reloc;
      logic [19:0] phys;
      logic [15:0] seg;
      logic [15:0] off;
      logic addr_valid;
      logic addr_io;
      logic cb_hit;
      sau_region_t region;
      logic [7:0] cb_off;
      logic [15:0] rdata;
      logic ready;
      logic [2:0] sync_ready_in_sync;
      logic [2:0] async_ready_in_sync;
      logic sync_ready_in;
      logic async_ready_in;
   } sau_state_t;
endpackage

// ===== sau_ea_calc.sv
// Effective offset, segment choice and physical address forming
`timescale 1ns/1ns
`include "sau_regs.svh"
module sau_ea_calc (
   input sau_pkg::sau_req_t req,
   input sau_pkg::sau_cpu_regs_t regs,
   output logic [15:0] seg,
   output logic [15:0] off,
   output logic [19:0] phys
);
   import sau_pkg::*;
   logic [15:0] disp_x;
   logic [15:0] base_v;
   logic [15:0] index_v;
   logic bp_base;
   sau_seg_t sel;

   // Offset arithmetic; 16-bit targets drop every carry [RULE_02]
   always_comb begin
      disp_x = req.disp8 ? {{8{req.disp[7]}}, req.disp[7:0]} // [RULE_08]
                         : req.disp;
      base_v = (req.base_sel == BASE_FRAME) ? regs.frame_base_reg
                                            : regs.general_base_reg;
      index_v = (req.index_sel == IDX_DEST) ? regs.dest_index_reg
                                            : regs.src_index_reg;
      bp_base = 1'b0;
      case (req.mode)
         MODE_DIRECT: off = disp_x; // [RULE_09]
         MODE_REG_IND: begin
            off = req.ind_use_base ? base_v : index_v; // [RULE_10]
            bp_base = req.ind_use_base && (req.base_sel == BASE_FRAME);
         end
         MODE_BASED: begin
            off = base_v + disp_x; // [RULE_11]
            bp_base = (req.base_sel == BASE_FRAME);
         end
         MODE_INDEXED: off = index_v + disp_x; // [RULE_12]
         MODE_BASED_IDX: begin
            off = base_v + index_v;
            bp_base = (req.base_sel == BASE_FRAME);
         end
         MODE_BASED_IDX_DISP: begin
            off = base_v + index_v + disp_x; // [RULE_13]
            bp_base = (req.base_sel == BASE_FRAME);
         end
         default: off = disp_x;
      endcase
      // Fetches, stack and string destinations take their own pointer
      case (req.kind)
         REF_CODE: off = regs.instr_ptr_reg;
         REF_STACK: off = regs.stack_ptr_reg;
         REF_STRING_DST: off = regs.dest_index_reg;
         default: off = off;
      endcase
      // Implicit segment choice, then any override of a data operand
      case (req.kind)
         REF_CODE: sel = SEG_CODE; // [RULE_03]
         REF_STACK: sel = SEG_STACK; // [RULE_04]
         REF_STRING_DST: sel = SEG_EXTRA; // [RULE_05]
         default: sel = bp_base ? SEG_STACK : SEG_DATA; // [RULE_04] [RULE_06]
      endcase
      if (req.ovr_valid && (req.kind == REF_DATA)) begin
         sel = req.ovr_seg; // [RULE_07]
      end
      case (sel)
         SEG_CODE: seg = regs.code_segment_reg;
         SEG_STACK: seg = regs.stack_segment_reg;
         SEG_EXTRA: seg = regs.extra_segment_reg;
         default: seg = regs.data_segment_reg;
      endcase
      // Port address: zero-extended field or port pointer [RULE_14]
      if (req.is_io) begin
         seg = 16'h0000;
         off = req.io_from_reg ? regs.port_pointer_reg
                               : {8'h00, req.io_port8};
         phys = {4'h0, off};
      end else begin
         phys = ({4'h0, seg} << `SAU_SEG_SHIFT) + {4'h0, off}; // [RULE_01]
      end
   end
endmodule

// ===== sau_cb_decode.sv
// Control block hit detection and register region decode
`timescale 1ns/1ns
`include "sau_regs.svh"
module sau_cb_decode (
   input logic [19:0] addr,
   input logic is_io,
   input logic [15:0] reloc,
   output logic hit,
   output sau_pkg::sau_region_t region,
   output logic [7:0] offset
);
   import sau_pkg::*;

   // Block sits on a 256-byte boundary in the space chosen by the mem bit
   always_comb begin
      offset = addr[7:0];
      hit = (is_io == !reloc[`SAU_RELOC_MEM_BIT]) && // [RULE_19] [RULE_25]
            (addr[19:8] == reloc[`SAU_RELOC_BASE_MSB:0]); // [RULE_17]
      // Region of the block that the offset falls in [RULE_23]
      if (offset >= `SAU_INT_LO && offset <= `SAU_INT_HI) begin
         region = RGN_INT;
      end else if (offset >= `SAU_TMR0_LO && offset <= `SAU_TMR0_HI) begin
         region = RGN_TMR0;
      end else if (offset >= `SAU_TMR1_LO && offset <= `SAU_TMR1_HI) begin
         region = RGN_TMR1;
      end else if (offset >= `SAU_TMR2_LO && offset <= `SAU_TMR2_HI) begin
         region = RGN_TMR2;
      end else if (offset >= `SAU_CHIPSEL_LO &&
                   offset <= `SAU_CHIPSEL_HI) begin
         region = RGN_CHIPSEL;
      end else if (offset >= `SAU_DMA0_LO && offset <= `SAU_DMA0_HI) begin
         region = RGN_DMA0;
      end else if (offset >= `SAU_DMA1_LO && offset <= `SAU_DMA1_HI) begin
         region = RGN_DMA1;
      end else if (offset == `SAU_RELOC_OFF) begin
         region = RGN_RELOC; // [RULE_18]
      end else begin
         region = RGN_NONE;
      end
   end
endmodule

// ===== sau_top.sv
// Segmented address unit: address forming and control block front end
// What this block does and what software must keep to
// [RULE_01] Physical address is segment shifted left four plus offset, 20 bits.
// [RULE_02] Carry out of the 16-bit offset sum is dropped; offset wraps.
// [RULE_03] Code segment bases instruction prefetch and immediate data fetch.
// [RULE_04] Stack segment for push, pop and frame-base-based references.
// [RULE_05] Extra segment for string references indexed by destination index.
// [RULE_06] Data segment for all other data references.
// [RULE_07] Override prefix replaces the implicit segment for that operand.
// [RULE_08] Eight-bit displacement is sign-extended to 16 bits before adding.
// [RULE_09] Direct mode: offset is the displacement alone.
// [RULE_10] Register indirect: offset is an index or base register unchanged.
// [RULE_11] Based mode: displacement plus general or frame base register.
// [RULE_12] Indexed mode: displacement plus source or destination index.
// [RULE_13] Based indexed with displacement: base plus index plus displacement.
// [RULE_14] Port address from zero-extended 8-bit field or port pointer.
// [RULE_15] Ports 00F8h to 00FFh are reserved; outside users leave them.
// [RULE_16] Control block cycles ignore external data and both ready inputs.
// [RULE_17] Block base on 256-byte boundary; relocation gives upper 12 bits.
// [RULE_18] Relocation register sits at offset FEh, read and written normally.
// [RULE_19] Relocation bit 12 set maps block to memory, clear to I/O.
// [RULE_20] Software keeps upper four base bits zero for I/O mapping.
// [RULE_21] Relocation register resets to 20FFh: block at FF00h in I/O.
// [RULE_22] Relocation register holds slave-mode and coprocessor-trap bits.
// [RULE_23] Decode interrupt, timer, chip-select and DMA register ranges.
// [RULE_24] Software avoids placing the block over a chip-select range.
// [RULE_25] Hit only when space matches and address bits above 7 match.
// [RULE_26] Every defined block register is accessible at any time.
`timescale 1ns/1ns
`include "sau_regs.svh"
module sau_top (
   input logic CLK,
   input logic RST_N,
   input sau_pkg::sau_req_t REQ,
   input sau_pkg::sau_cpu_regs_t REGS,
   input logic [15:0] PERIPH_RDATA,
   input logic [15:0] EXT_DATA,
   input logic SYNC_READY_IN,
   input logic ASYNC_READY_IN,
   output logic [19:0] PHYS_ADDR,
   output logic [15:0] SEG_BASE,
   output logic [15:0] EFF_OFFSET,
   output logic ADDR_VALID,
   output logic ADDR_IO,
   output logic CB_HIT,
   output sau_pkg::sau_region_t CB_REGION,
   output logic [7:0] CB_OFFSET,
   output logic [15:0] RD_DATA,
   output logic BUS_READY,
   output logic [15:0] RELOC_VALUE,
   output logic CB_IN_MEMORY,
   output logic INT_SLAVE_MODE,
   output logic COPROC_TRAP_EN
);
   import sau_pkg::*;

   sau_state_t s;
   sau_state_t next_s;
   logic [15:0] ea_seg;
   logic [15:0] ea_off;
   logic [19:0] ea_phys;
   logic dec_hit;
   sau_region_t dec_region;
   logic [7:0] dec_off;
   logic req_hit;
   logic reloc_wr;

   // Offset, segment and physical address of the current request
   sau_ea_calc u_ea (
      .req(REQ),
      .regs(REGS),
      .seg(ea_seg),
      .off(ea_off),
      .phys(ea_phys)
   );

   // Control block decode against the current relocation value
   sau_cb_decode u_cb (
      .addr(ea_phys),
      .is_io(REQ.is_io),
      .reloc(s.reloc),
      .hit(dec_hit),
      .region(dec_region),
      .offset(dec_off)
   );

   // Access strobes for this cycle
   assign req_hit = REQ.valid && dec_hit;
   assign reloc_wr = req_hit && REQ.write && (dec_off == `SAU_RELOC_OFF);

   // Next state of the whole unit
   always_comb begin
      next_s = s;
      // Ready pins: three stages, a change counts when stages 2 and 3 agree
      next_s.sync_ready_in_sync = {s.sync_ready_in_sync[1:0], SYNC_READY_IN};
      next_s.async_ready_in_sync = {s.async_ready_in_sync[1:0], ASYNC_READY_IN};
      if (s.sync_ready_in_sync[2] == s.sync_ready_in_sync[1]) begin
         next_s.sync_ready_in = s.sync_ready_in_sync[2];
      end
      if (s.async_ready_in_sync[2] == s.async_ready_in_sync[1]) begin
         next_s.async_ready_in = s.async_ready_in_sync[2];
      end
      // Latch the formed address of each request
      next_s.addr_valid = REQ.valid;
      next_s.cb_hit = req_hit;
      if (REQ.valid) begin
         next_s.phys = ea_phys;
         next_s.seg = ea_seg;
         next_s.off = ea_off;
         next_s.addr_io = REQ.is_io;
         next_s.cb_off = dec_off;
         next_s.region = dec_hit ? dec_region : RGN_NONE;
      end
      // Relocation register write, reserved top bit kept zero
      if (reloc_wr) begin
         next_s.reloc = REQ.wdata & `SAU_RELOC_WMASK; // [RULE_18] [RULE_26]
      end
      // Read data: block registers replace the external bus [RULE_16]
      if (req_hit) begin
         if (dec_off == `SAU_RELOC_OFF) begin
            next_s.rdata = s.reloc; // [RULE_18]
         end else if (dec_region != RGN_NONE) begin
            next_s.rdata = PERIPH_RDATA; // [RULE_26]
         end else begin
            next_s.rdata = 16'h0000;
         end
      end else if (REQ.valid) begin
         next_s.rdata = EXT_DATA;
      end
      // Internal cycles complete without waiting on the ready pins
      next_s.ready = req_hit ? 1'b1 : (s.sync_ready_in | s.async_ready_in); // [RULE_16]
   end

   // State register; relocation value comes up at its reset pattern
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s <= '0;
         s.reloc <= `SAU_RELOC_RESET; // [RULE_21]
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign PHYS_ADDR = s.phys;
   assign SEG_BASE = s.seg;
   assign EFF_OFFSET = s.off;
   assign ADDR_VALID = s.addr_valid;
   assign ADDR_IO = s.addr_io;
   assign CB_HIT = s.cb_hit;
   assign CB_REGION = s.region;
   assign CB_OFFSET = s.cb_off;
   assign RD_DATA = s.rdata;
   assign BUS_READY = s.ready;
   assign RELOC_VALUE = s.reloc;
   assign CB_IN_MEMORY = s.reloc[`SAU_RELOC_MEM_BIT]; // [RULE_19]
   assign INT_SLAVE_MODE = s.reloc[`SAU_RELOC_SLAVE_BIT]; // [RULE_22]
   assign COPROC_TRAP_EN = s.reloc[`SAU_RELOC_TRAP_BIT]; // [RULE_22]

   // Checks on the registered results
   default clocking cb_clk @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   // Memory address equals shifted segment plus offset
   AST_PHYS_SUM: assert property ( // [RULE_01]
      ADDR_VALID && !ADDR_IO |->
         PHYS_ADDR == (({4'h0, SEG_BASE} << 4) + {4'h0, EFF_OFFSET}))
      else $error("physical address is not segment*16 plus offset");

   // Direct mode with a short displacement gives the sign-extended byte
   AST_DIRECT_DISP8: assert property ( // [RULE_08]
      REQ.valid && !REQ.is_io && REQ.kind == REF_DATA &&
      REQ.mode == MODE_DIRECT && REQ.disp8 |=>
         EFF_OFFSET == {{8{$past(REQ.disp[7])}}, $past(REQ.disp[7:0])})
      else $error("short displacement not sign extended");

   // Based mode sum wraps within 16 bits
   AST_BASED_WRAP: assert property ( // [RULE_02]
      REQ.valid && !REQ.is_io && REQ.kind == REF_DATA &&
      REQ.mode == MODE_BASED && REQ.base_sel == BASE_GENERAL &&
      !REQ.disp8 |=>
         EFF_OFFSET == 16'($past(REGS.general_base_reg) + $past(REQ.disp)))
      else $error("based offset does not wrap in 16 bits");

   // Fetches take the code segment
   AST_CODE_SEG: assert property ( // [RULE_03]
      REQ.valid && !REQ.is_io && REQ.kind == REF_CODE |=>
         SEG_BASE == $past(REGS.code_segment_reg))
      else $error("fetch not based on code segment");

   // Frame base references default to the stack segment
   AST_FRAME_SEG: assert property ( // [RULE_04]
      REQ.valid && !REQ.is_io && REQ.kind == REF_DATA && !REQ.ovr_valid &&
      REQ.mode == MODE_BASED && REQ.base_sel == BASE_FRAME |=>
         SEG_BASE == $past(REGS.stack_segment_reg))
      else $error("frame base reference not in stack segment");

   // String destinations use the extra segment and destination index
   AST_STRING_DST: assert property ( // [RULE_05]
      REQ.valid && !REQ.is_io && REQ.kind == REF_STRING_DST |=>
         SEG_BASE == $past(REGS.extra_segment_reg) &&
         EFF_OFFSET == $past(REGS.dest_index_reg))
      else $error("string destination not extra segment");

   // An override to the extra segment wins over the data segment
   AST_OVERRIDE: assert property ( // [RULE_07]
      REQ.valid && !REQ.is_io && REQ.kind == REF_DATA && REQ.ovr_valid &&
      REQ.ovr_seg == SEG_EXTRA |=>
         SEG_BASE == $past(REGS.extra_segment_reg))
      else $error("segment override ignored");

   // Short port numbers come out zero-extended
   AST_IO_PORT8: assert property ( // [RULE_14]
      REQ.valid && REQ.is_io && !REQ.io_from_reg |=>
         ADDR_IO && PHYS_ADDR == {12'h000, $past(REQ.io_port8)})
      else $error("short port number not zero extended");

   // Control block cycles are ready regardless of the ready pins
   AST_CB_READY: assert property ( // [RULE_16]
      CB_HIT |-> BUS_READY)
      else $error("control block cycle waited on ready");

   // A relocation write shows on the register one edge later
   AST_RELOC_WRITE: assert property ( // [RULE_18]
      reloc_wr |=> RELOC_VALUE == ($past(REQ.wdata) & 16'h7fff)
         ##1 RELOC_VALUE == $past(RELOC_VALUE) || $past(reloc_wr))
      else $error("relocation write lost");

   // Relocation value only changes through a write or a reset
   AST_RELOC_STABLE: assert property ( // [RULE_21]
      !reloc_wr |=> $stable(RELOC_VALUE))
      else $error("relocation register changed without a write");

   // A hit always lies in the programmed space and page
   AST_HIT_MATCH: assert property ( // [RULE_25]
      CB_HIT |-> (ADDR_IO == !$past(RELOC_VALUE[12])) &&
         PHYS_ADDR[19:8] == $past(RELOC_VALUE[11:0]))
      else $error("control block hit outside its page");

   // Main scenarios
   CVR_RELOC_READ: cover property (
      REQ.valid && !REQ.write ##1 CB_HIT && CB_REGION == RGN_RELOC);
   CVR_MEM_BLOCK: cover property (CB_HIT && !ADDR_IO);
   CVR_TIMER_HIT: cover property (CB_HIT && CB_REGION == RGN_TMR1);
   CVR_RSVD_PORT: cover property (
      ADDR_VALID && ADDR_IO && PHYS_ADDR >= {4'h0, `SAU_RSVD_PORT_LO} &&
      PHYS_ADDR <= {4'h0, `SAU_RSVD_PORT_HI});
endmodule

// ===== sau_ext_bus.sv
// Behavioural model of the external memory and I/O bus partner
`timescale 1ns/1ns
module sau_ext_bus (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hold_low,
   output logic [15:0] ext_data,
   output logic sync_rdy,
   output logic async_rdy
);
   initial begin
      ext_data = 16'h0001;
      sync_rdy = 1'b0;
      async_rdy = 1'b0;
   end
   // Data lines change every cycle so a stale value never passes
   always @(posedge clk) begin
      ext_data <= #1 ext_data * 16'h6255 + 16'h3619;
      // Ready answers promptly unless held off; async one lands off-edge
      sync_rdy <= #1 !hold_low;
      async_rdy <= #3 !hold_low && rst_n;
   end
endmodule

// ===== tb.sv
// Self-checking bench for the segmented address unit
`timescale 1ns/1ns
module tb;
   import sau_pkg::*;
   typedef struct packed {
      logic [19:0] phys;
      logic [15:0] seg;
      logic [15:0] off;
      logic io;
      logic hit;
      sau_region_t rgn;
      logic [15:0] rd;
      logic wr;
      logic [15:0] rel;
   } sau_exp_t;
   logic clk, rst_n, hold_low, sync_rdy, async_rdy;
   sau_req_t req;
   sau_cpu_regs_t regs;
   logic [15:0] periph_rdata, ext_data, m_reloc;
   logic [19:0] phys_addr;
   logic [15:0] seg_base, eff_offset, rd_data, reloc_value;
   logic addr_valid, addr_io, cb_hit, bus_ready;
   logic cb_in_memory, int_slave_mode, coproc_trap_en;
   sau_region_t cb_region;
   logic [7:0] cb_offset;
   sau_exp_t q[$];
   int num_errors, cmp_count, cycles, n;
   logic [7:0] offs [18] = '{8'h20, 8'h3e, 8'h50, 8'h56, 8'h58, 8'h5e,
      8'h60, 8'h66, 8'ha0, 8'ha8, 8'hc0, 8'hca, 8'hd0, 8'hda, 8'hfe,
      8'h1e, 8'h40, 8'he0};
   sau_top dut (
      .CLK(clk), .RST_N(rst_n), .REQ(req), .REGS(regs),
      .PERIPH_RDATA(periph_rdata), .EXT_DATA(ext_data),
      .SYNC_READY_IN(sync_rdy), .ASYNC_READY_IN(async_rdy),
      .PHYS_ADDR(phys_addr), .SEG_BASE(seg_base),
      .EFF_OFFSET(eff_offset), .ADDR_VALID(addr_valid),
      .ADDR_IO(addr_io), .CB_HIT(cb_hit), .CB_REGION(cb_region),
      .CB_OFFSET(cb_offset), .RD_DATA(rd_data), .BUS_READY(bus_ready),
      .RELOC_VALUE(reloc_value), .CB_IN_MEMORY(cb_in_memory),
      .INT_SLAVE_MODE(int_slave_mode), .COPROC_TRAP_EN(coproc_trap_en)
   );
   sau_ext_bus bus (
      .clk(clk), .rst_n(rst_n), .hold_low(hold_low),
      .ext_data(ext_data), .sync_rdy(sync_rdy), .async_rdy(async_rdy)
   );
   // Clock at 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_reset();
      chk(reloc_value, 16'h20ff);
      chk({int_slave_mode, coproc_trap_en, cb_in_memory}, 3'h2);
      chk(addr_valid, 1'b0);
   endtask
   // Compare the registered result with the model's expectation
   task automatic verify(input sau_exp_t e);
      chk(addr_valid, 1'b1);
      chk(phys_addr, e.phys);
      chk(seg_base, e.seg);
      chk(eff_offset, e.off);
      chk(eff_offset, e.off);
      chk(addr_io, e.io);
      chk(cb_hit, e.hit);
      chk(cb_region, e.rgn);
      chk(cb_offset, e.phys[7:0]);
      if (!e.wr) chk(rd_data, e.rd);
      chk(bus_ready, e.hit);
      chk(reloc_value, e.rel);
      chk({int_slave_mode, coproc_trap_en, cb_in_memory},
         e.rel[14:12]);
   endtask
   function automatic sau_cpu_regs_t rnd_regs();
      logic [191:0] v;
      v = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      return v[175:0];
   endfunction
   // Drive one request at the falling edge and queue its expected result
   task automatic send(input sau_req_t r, input sau_cpu_regs_t g);
      sau_exp_t e;
      logic [15:0] d, b, x;
      logic [7:0] o;
      logic fb;
      @(negedge clk);
      if (q.size() > 0) verify(q.pop_front());
      else chk(addr_valid, 1'b0);
      periph_rdata = 16'($urandom);
      req = r;
      regs = g;
      if (!r.valid) return;
      d = r.disp8 ? {{8{r.disp[7]}}, r.disp[7:0]} : r.disp;
      b = r.base_sel == BASE_FRAME ? g.frame_base_reg : g.general_base_reg;
      x = r.index_sel == IDX_DEST ? g.dest_index_reg : g.src_index_reg;
      e = '0;
      e.io = r.is_io;
      e.wr = r.write;
      if (r.is_io) begin
         e.off = r.io_from_reg ? g.port_pointer_reg : {8'h00, r.io_port8};
      end else if (r.kind == REF_CODE) begin
         e.seg = g.code_segment_reg;
         e.off = g.instr_ptr_reg;
      end else if (r.kind == REF_STACK) begin
         e.seg = g.stack_segment_reg;
         e.off = g.stack_ptr_reg;
      end else if (r.kind == REF_STRING_DST) begin
         e.seg = g.extra_segment_reg;
         e.off = g.dest_index_reg;
      end else begin
         case (r.mode)
            MODE_DIRECT: e.off = d;
            MODE_REG_IND: e.off = r.ind_use_base ? b : x;
            MODE_BASED: e.off = b + d;
            MODE_INDEXED: e.off = x + d;
            MODE_BASED_IDX: e.off = b + x;
            default: e.off = b + x + d;
         endcase
         fb = r.mode inside {MODE_BASED, MODE_BASED_IDX, MODE_BASED_IDX_DISP};
         fb = (fb || (r.mode == MODE_REG_IND && r.ind_use_base));
         fb = fb && r.base_sel == BASE_FRAME;
         e.seg = fb ? g.stack_segment_reg : g.data_segment_reg;
         if (r.ovr_valid) begin
            case (r.ovr_seg)
               SEG_EXTRA: e.seg = g.extra_segment_reg;
               SEG_CODE: e.seg = g.code_segment_reg;
               SEG_STACK: e.seg = g.stack_segment_reg;
               default: e.seg = g.data_segment_reg;
            endcase
         end
      end
      e.phys = {e.seg, 4'h0} + {4'h0, e.off};
      o = e.phys[7:0];
      e.hit = (r.is_io != m_reloc[12]) && (e.phys[19:8] == m_reloc[11:0]);
      e.rgn = RGN_NONE;
      if (e.hit) begin
         if (o inside {[8'h20:8'h3e]}) e.rgn = RGN_INT;
         if (o inside {[8'h50:8'h56]}) e.rgn = RGN_TMR0;
         if (o inside {[8'h58:8'h5e]}) e.rgn = RGN_TMR1;
         if (o inside {[8'h60:8'h66]}) e.rgn = RGN_TMR2;
         if (o inside {[8'ha0:8'ha8]}) e.rgn = RGN_CHIPSEL;
         if (o inside {[8'hc0:8'hca]}) e.rgn = RGN_DMA0;
         if (o inside {[8'hd0:8'hda]}) e.rgn = RGN_DMA1;
         if (o == 8'hfe) e.rgn = RGN_RELOC;
      end
      e.rd = (e.rgn != RGN_NONE) ? periph_rdata : 16'h0;
      if (o == 8'hfe) e.rd = m_reloc;
      if (!e.hit) e.rd = ext_data;
      if (r.write && e.hit && o == 8'hfe) m_reloc = r.wdata & 16'h7fff;
      e.rel = m_reloc;
      q.push_back(e);
   endtask
   // Data read or write: memory via data segment, I/O via port pointer
   task automatic acc(input logic [15:0] s, a, input logic mem, wr,
         input logic [15:0] wd);
      sau_req_t r;
      sau_cpu_regs_t g;
      g = rnd_regs();
      r = '0;
      r.valid = 1'b1;
      r.kind = REF_DATA;
      r.is_io = !mem;
      r.io_from_reg = 1'b1;
      r.write = wr;
      r.wdata = wd;
      r.disp = a;
      g.port_pointer_reg = a;
      g.data_segment_reg = s;
      send(r, g);
   endtask
   // Main sequence
   initial begin
      sau_req_t r;
      sau_cpu_regs_t g;
      logic [63:0] v;
      rst_n = 1'b0;
      hold_low = 1'b1;
      req = '0;
      regs = '0;
      periph_rdata = '0;
      m_reloc = 16'h20ff;
      void'($urandom(93));
      repeat (4) @(negedge clk);
      chk_reset();
      rst_n = 1'b1;
      // Block at its reset place in I/O space, then misses
      foreach (offs[i]) acc(16'h0, {8'hff, offs[i]}, 1'b0, 1'b0, 16'h0);
      acc(16'h0, 16'hfefe, 1'b0, 1'b0, 16'h0);
      acc(16'hff00, 16'h00fe, 1'b1, 1'b0, 16'h0);
      // Move block to memory 0A000; bit 15 written high
      acc(16'h0, 16'hfffe, 1'b0, 1'b1, 16'h90a0);
      foreach (offs[i]) acc(16'ha000, {8'h00, offs[i]}, 1'b1, 1'b0, 16'h0);
      // Try I/O at 1200 with trap and slave bits via carry path; A00FE misses, block stays in memory
      acc(16'h9ff0, 16'h01fe, 1'b1, 1'b1, 16'h6012);
      acc(16'h0, 16'h12fe, 1'b0, 1'b0, 16'h0);
      acc(16'h0, 16'hfffe, 1'b0, 1'b0, 16'h0);
      acc(16'h0, 16'h12fe, 1'b0, 1'b1, 16'h20ff);
      // Ready pins: pin edge, three stages, agree, output register
      repeat (2) send('0, regs);
      hold_low = 1'b0;
      n = 0;
      while (bus_ready !== 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      chk(20'(n), 20'd6);
      hold_low = 1'b1;
      repeat (8) send('0, regs);
      // Random traffic, back to back
      repeat (400) begin
         g = rnd_regs();
         v = {$urandom, $urandom};
         r = v[55:0];
         r.valid = 1'b1;
         r.write = 1'b0;
         r.kind = sau_ref_t'(2'($urandom));
         r.mode = sau_mode_t'(3'($urandom % 6));
         if (r.io_port8 > 8'hf7) r.io_port8[3] = 1'b0;
         if ($urandom % 4 == 0) g.port_pointer_reg[15:8] = 8'hff;
         if (g.port_pointer_reg[15:3] == 13'h1f) g.port_pointer_reg[8] = 1'b1;
         send(r, g);
      end
      // Reset in mid-run restores the relocation register
      acc(16'h0, 16'hfffe, 1'b0, 1'b1, 16'h1234);
      send('0, regs);
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      chk_reset();
      m_reloc = 16'h20ff;
      rst_n = 1'b1;
      acc(16'h0, 16'hfffe, 1'b0, 1'b0, 16'h0);
      send('0, regs);
      wrap_up();
   end
endmodule
